//--- include/iosd_defs.vh
// constants for the i/o space decoder
// Functional notes
// - bit set/clear works on 0x00..0x1F registers
// - bit skip tests sample one register bit
// - writing one clears flag, zero keeps it
// - bit set/clear touches only addressed bit
// - bit operations decoded only below 0x20
// - in/out use short addresses 0x00..0x3F
// - data space address is short address plus 0x20
// - short field gives 64 locations, rest extended
// - extended 0x60..0xFF reached only by loads/stores
// - large-variant bits read reserved on small variant
`ifndef IOSD_DEFS_VH
`define IOSD_DEFS_VH
`define IOSD_IO_OFFSET 8'h20
`define IOSD_IO_LOCS 8'h40
`define IOSD_BIT_LIMIT 6'h20
`define IOSD_EXT_LO 8'h60
`define IOSD_A_PORT_B_INPUT_PINS 6'h03
`define IOSD_A_PORT_B_DIRECTION 6'h04
`define IOSD_A_PORT_B_OUTPUT_DATA 6'h05
`define IOSD_A_PORT_C_INPUT_PINS 6'h06
`define IOSD_A_PORT_C_DIRECTION 6'h07
`define IOSD_A_PORT_C_OUTPUT_DATA 6'h08
`define IOSD_A_PORT_D_INPUT_PINS 6'h09
`define IOSD_A_PORT_D_DIRECTION 6'h0A
`define IOSD_A_PORT_D_OUTPUT_DATA 6'h0B
`define IOSD_A_TF0 6'h15
`define IOSD_A_TF1 6'h16
`define IOSD_A_TF2 6'h17
`define IOSD_A_PCF 6'h1B
`define IOSD_A_EIF 6'h1C
`define IOSD_A_EIM 6'h1D
`define IOSD_A_SPH 6'h3E
`define IOSD_A_SPMC 6'h37
`define IOSD_M_PORT_C_OUTPUT_DATA 8'h7F
`define IOSD_M_TF0 8'h07
`define IOSD_M_TF1 8'h27
`define IOSD_M_TF2 8'h07
`define IOSD_M_PCF 8'h07
`define IOSD_M_EIF 8'h03
`define IOSD_M_EIM 8'h03
`define IOSD_M_SPH_SMALL 8'h03
`define IOSD_M_SPH_BIG 8'h07
`define IOSD_SPH_TOP_BIT 2
`define IOSD_RWW_BIT 6
`define IOSD_RST 8'h00
`define IOSD_OP_NONE 3'h0
`define IOSD_OP_IN 3'h1
`define IOSD_OP_OUT 3'h2
`define IOSD_OP_LD 3'h3
`define IOSD_OP_ST 3'h4
`define IOSD_OP_SBI 3'h5
`define IOSD_OP_CBI 3'h6
`define IOSD_OP_SKIP 3'h7
`endif

//--- hw/iosd_rw_reg.v
// one plain read/write register with implemented-bit mask
`timescale 1ns/1ps
`include "iosd_defs.vh"
module iosd_rw_reg #(
	parameter [7:0] MASK = 8'hFF
) (
	input wire core_clk_i,
	input wire srst_i,
	input wire we_i,
	input wire [7:0] wdata_i,
	output wire [7:0] q_o
);
	reg [7:0] val_q;
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			val_q <= `IOSD_RST;
		end else if (we_i) begin
			val_q <= wdata_i & MASK;
		end
	end
	assign q_o = val_q;
endmodule // iosd_rw_reg

//--- hw/iosd_flag_reg.v
// one write-one-to-clear flag register, hardware set wins
`timescale 1ns/1ps
`include "iosd_defs.vh"
module iosd_flag_reg #(
	parameter [7:0] MASK = 8'hFF
) (
	input wire core_clk_i,
	input wire srst_i,
	input wire [7:0] set_i,
	input wire [7:0] clr_i,
	output wire [7:0] q_o
);
	reg [7:0] flag_q;
	reg [7:0] flag_d;
	always @* begin
		flag_d = (flag_q & ~clr_i) | set_i;
		flag_d = flag_d & MASK;
	end
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			flag_q <= `IOSD_RST;
		end else begin
			flag_q <= flag_d;
		end
	end
	assign q_o = flag_q;
endmodule // iosd_flag_reg

//--- hw/iosd_decoder.v
// i/o space decoder with bit access and flag registers
`timescale 1ns/1ps
`include "iosd_defs.vh"
module iosd_decoder #(
	parameter LARGE_VARIANT = 1
) (
	input wire core_clk_i,
	input wire srst_i,
	input wire [2:0] op_i,
	input wire [7:0] addr_i,
	input wire [2:0] bit_i,
	input wire [7:0] wdata_i,
	input wire [7:0] port_b_input_pins_i,
	input wire [6:0] port_c_input_pins_i,
	input wire [7:0] port_d_input_pins_i,
	input wire [7:0] tf0_set_i,
	input wire [7:0] tf1_set_i,
	input wire [7:0] tf2_set_i,
	input wire [7:0] pcf_set_i,
	input wire [7:0] eif_set_i,
	input wire [7:0] sph_i,
	input wire [7:0] spmc_i,
	input wire [7:0] ext_rdata_i,
	output reg [7:0] rdata_o,
	output reg skip_o,
	output reg ext_we_o,
	output reg ext_re_o,
	output reg [7:0] ext_addr_o,
	output reg [7:0] ext_wdata_o,
	output wire [7:0] port_b_direction_o,
	output wire [7:0] port_b_output_data_o,
	output wire [7:0] port_c_direction_o,
	output wire [7:0] port_c_output_data_o,
	output wire [7:0] port_d_direction_o,
	output wire [7:0] port_d_output_data_o,
	output wire [7:0] timer0_flags_o,
	output wire [7:0] timer1_flags_o,
	output wire [7:0] timer2_flags_o,
	output wire [7:0] pin_change_flags_o,
	output wire [7:0] external_irq_flags_o,
	output wire [7:0] external_irq_mask_o
);
	// bit position to one-hot mask
	function [7:0] onehot;
		input [2:0] b;
		begin
			onehot = 8'h01 << b;
		end
	endfunction

	// is this short address a flag register
	function is_flag;
		input [5:0] a;
		begin
			is_flag = (a == `IOSD_A_TF0) || (a == `IOSD_A_TF1) || (a == `IOSD_A_TF2) ||
				(a == `IOSD_A_PCF) || (a == `IOSD_A_EIF);
		end
	endfunction

	wire is_io_op;
	wire is_data_op;
	wire is_bit_op;
	wire data_in_io;
	wire io_hit;
	wire io_wr;
	wire io_rd;
	reg [5:0] ioa;
	reg [7:0] cur;
	reg [7:0] wval;
	reg [7:0] clr_v;
	reg [7:0] sph_mask;
	reg [7:0] spmc_mask;

	assign is_io_op = (op_i == `IOSD_OP_IN) || (op_i == `IOSD_OP_OUT);
	assign is_data_op = (op_i == `IOSD_OP_LD) || (op_i == `IOSD_OP_ST);
	assign is_bit_op = ((op_i == `IOSD_OP_SBI) || (op_i == `IOSD_OP_CBI) ||
		(op_i == `IOSD_OP_SKIP)) && (addr_i[5:0] < `IOSD_BIT_LIMIT) && (addr_i[7:6] == 2'b00);
	assign data_in_io = is_data_op && (addr_i >= `IOSD_IO_OFFSET) &&
		(addr_i < (`IOSD_IO_OFFSET + `IOSD_IO_LOCS));
	assign io_hit = (is_io_op && (addr_i < `IOSD_IO_LOCS)) || data_in_io || is_bit_op;
	assign io_wr = io_hit && ((op_i == `IOSD_OP_OUT) || (op_i == `IOSD_OP_ST) ||
		(op_i == `IOSD_OP_SBI) || (op_i == `IOSD_OP_CBI));
	assign io_rd = io_hit && !io_wr;

	always @* begin
		ioa = data_in_io ? (addr_i[5:0] - 6'h20) : addr_i[5:0];
		sph_mask = LARGE_VARIANT ? `IOSD_M_SPH_BIG : `IOSD_M_SPH_SMALL;
		spmc_mask = LARGE_VARIANT ? 8'hFF : ~onehot(`IOSD_RWW_BIT);
	end

	wire [7:0] port_b_direction_q;
	wire [7:0] port_b_output_data_q;
	wire [7:0] port_c_direction_q;
	wire [7:0] port_c_output_data_q;
	wire [7:0] port_d_direction_q;
	wire [7:0] port_d_output_data_q;
	wire [7:0] eim_q;
	wire [7:0] tf0_q;
	wire [7:0] tf1_q;
	wire [7:0] tf2_q;
	wire [7:0] pcf_q;
	wire [7:0] eif_q;

	// current register value, zero when unmapped
	always @* begin
		case (ioa)
			`IOSD_A_PORT_B_INPUT_PINS: cur = port_b_input_pins_i;
			`IOSD_A_PORT_B_DIRECTION: cur = port_b_direction_q;
			`IOSD_A_PORT_B_OUTPUT_DATA: cur = port_b_output_data_q;
			`IOSD_A_PORT_C_INPUT_PINS: cur = {1'b0, port_c_input_pins_i};
			`IOSD_A_PORT_C_DIRECTION: cur = port_c_direction_q;
			`IOSD_A_PORT_C_OUTPUT_DATA: cur = port_c_output_data_q;
			`IOSD_A_PORT_D_INPUT_PINS: cur = port_d_input_pins_i;
			`IOSD_A_PORT_D_DIRECTION: cur = port_d_direction_q;
			`IOSD_A_PORT_D_OUTPUT_DATA: cur = port_d_output_data_q;
			`IOSD_A_TF0: cur = tf0_q;
			`IOSD_A_TF1: cur = tf1_q;
			`IOSD_A_TF2: cur = tf2_q;
			`IOSD_A_PCF: cur = pcf_q;
			`IOSD_A_EIF: cur = eif_q;
			`IOSD_A_EIM: cur = eim_q;
			`IOSD_A_SPH: cur = sph_i & sph_mask;
			`IOSD_A_SPMC: cur = spmc_i & spmc_mask;
			default: cur = 8'h00;
		endcase
	end

	// write value and flag-clear vector
	always @* begin
		wval = wdata_i;
		clr_v = 8'h00;
		case (op_i)
			`IOSD_OP_SBI: wval = cur | onehot(bit_i);
			`IOSD_OP_CBI: wval = cur & ~onehot(bit_i);
			default: wval = wdata_i;
		endcase
		if (io_wr && is_flag(ioa)) begin
			if (op_i == `IOSD_OP_SBI) begin
				clr_v = onehot(bit_i);
			end else if (op_i == `IOSD_OP_CBI) begin
				clr_v = 8'h00;
			end else begin
				clr_v = wdata_i;
			end
		end
	end

	wire we_port_b_direction = io_wr && (ioa == `IOSD_A_PORT_B_DIRECTION);
	wire we_port_b_output_data = io_wr && (ioa == `IOSD_A_PORT_B_OUTPUT_DATA);
	wire we_port_c_direction = io_wr && (ioa == `IOSD_A_PORT_C_DIRECTION);
	wire we_port_c_output_data = io_wr && (ioa == `IOSD_A_PORT_C_OUTPUT_DATA);
	wire we_port_d_direction = io_wr && (ioa == `IOSD_A_PORT_D_DIRECTION);
	wire we_port_d_output_data = io_wr && (ioa == `IOSD_A_PORT_D_OUTPUT_DATA);
	wire we_eim = io_wr && (ioa == `IOSD_A_EIM);

	iosd_rw_reg #(.MASK(8'hFF)) u_port_b_direction (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.we_i(we_port_b_direction), .wdata_i(wval), .q_o(port_b_direction_q));
	iosd_rw_reg #(.MASK(8'hFF)) u_port_b_output_data (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.we_i(we_port_b_output_data), .wdata_i(wval), .q_o(port_b_output_data_q));
	iosd_rw_reg #(.MASK(`IOSD_M_PORT_C_OUTPUT_DATA)) u_port_c_direction (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.we_i(we_port_c_direction), .wdata_i(wval), .q_o(port_c_direction_q));
	iosd_rw_reg #(.MASK(`IOSD_M_PORT_C_OUTPUT_DATA)) u_port_c_output_data (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.we_i(we_port_c_output_data), .wdata_i(wval), .q_o(port_c_output_data_q));
	iosd_rw_reg #(.MASK(8'hFF)) u_port_d_direction (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.we_i(we_port_d_direction), .wdata_i(wval), .q_o(port_d_direction_q));
	iosd_rw_reg #(.MASK(8'hFF)) u_port_d_output_data (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.we_i(we_port_d_output_data), .wdata_i(wval), .q_o(port_d_output_data_q));
	iosd_rw_reg #(.MASK(`IOSD_M_EIM)) u_eim (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.we_i(we_eim), .wdata_i(wval), .q_o(eim_q));

	iosd_flag_reg #(.MASK(`IOSD_M_TF0)) u_tf0 (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.set_i(tf0_set_i), .clr_i((ioa == `IOSD_A_TF0) ? clr_v : 8'h00), .q_o(tf0_q));
	iosd_flag_reg #(.MASK(`IOSD_M_TF1)) u_tf1 (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.set_i(tf1_set_i), .clr_i((ioa == `IOSD_A_TF1) ? clr_v : 8'h00), .q_o(tf1_q));
	iosd_flag_reg #(.MASK(`IOSD_M_TF2)) u_tf2 (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.set_i(tf2_set_i), .clr_i((ioa == `IOSD_A_TF2) ? clr_v : 8'h00), .q_o(tf2_q));
	iosd_flag_reg #(.MASK(`IOSD_M_PCF)) u_pcf (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.set_i(pcf_set_i), .clr_i((ioa == `IOSD_A_PCF) ? clr_v : 8'h00), .q_o(pcf_q));
	iosd_flag_reg #(.MASK(`IOSD_M_EIF)) u_eif (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.set_i(eif_set_i), .clr_i((ioa == `IOSD_A_EIF) ? clr_v : 8'h00), .q_o(eif_q));

	// registered answers and extended space strobes
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			rdata_o <= 8'h00;
			skip_o <= 1'b0;
			ext_we_o <= 1'b0;
			ext_re_o <= 1'b0;
			ext_addr_o <= 8'h00;
			ext_wdata_o <= 8'h00;
		end else begin
			skip_o <= (op_i == `IOSD_OP_SKIP) && is_bit_op && cur[bit_i];
			ext_we_o <= (op_i == `IOSD_OP_ST) && (addr_i >= `IOSD_EXT_LO);
			ext_re_o <= (op_i == `IOSD_OP_LD) && (addr_i >= `IOSD_EXT_LO);
			ext_addr_o <= addr_i;
			ext_wdata_o <= wdata_i;
			if (io_rd) begin
				rdata_o <= cur;
			end else if ((op_i == `IOSD_OP_LD) && (addr_i >= `IOSD_EXT_LO)) begin
				rdata_o <= ext_rdata_i;
			end else begin
				rdata_o <= 8'h00;
			end
		end
	end

	assign port_b_direction_o = port_b_direction_q;
	assign port_b_output_data_o = port_b_output_data_q;
	assign port_c_direction_o = port_c_direction_q;
	assign port_c_output_data_o = port_c_output_data_q;
	assign port_d_direction_o = port_d_direction_q;
	assign port_d_output_data_o = port_d_output_data_q;
	assign timer0_flags_o = tf0_q;
	assign timer1_flags_o = tf1_q;
	assign timer2_flags_o = tf2_q;
	assign pin_change_flags_o = pcf_q;
	assign external_irq_flags_o = eif_q;
	assign external_irq_mask_o = eim_q;
endmodule // iosd_decoder

//--- sim/iosd_decoder_checker.sv
// concurrent checks on the i/o space decoder ports
`timescale 1ns/1ps
module iosd_decoder_checker (
	input logic core_clk_i,
	input logic srst_i,
	input logic [2:0] op_i,
	input logic [7:0] addr_i,
	input logic [2:0] bit_i,
	input logic [7:0] wdata_i,
	input logic [7:0] tf0_set_i,
	input logic skip_o,
	input logic ext_we_o,
	input logic [7:0] ext_addr_o,
	input logic [7:0] port_b_output_data_o,
	input logic [7:0] timer0_flags_o,
	input logic [7:0] external_irq_flags_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	ext_store_a: assert property (
		op_i == 3'h4 && addr_i >= 8'h60 |=> ext_we_o && ext_addr_o == $past(addr_i))
		else $error("extended store not forwarded");
	out_no_ext_a: assert property (
		op_i == 3'h2 |=> !ext_we_o) else $error("short write reached extended space");
	bit_range_a: assert property (
		op_i == 3'h7 && addr_i >= 8'h20 |=> !skip_o) else $error("bit test above range");
	out_port_b_output_data_a: assert property (
		op_i == 3'h2 && addr_i == 8'h05 |=> port_b_output_data_o == $past(wdata_i))
		else $error("short write to port b lost");
	store_port_b_output_data_a: assert property (
		op_i == 3'h4 && addr_i == 8'h25 |=> port_b_output_data_o == $past(wdata_i))
		else $error("offset store to port b lost");
	sbi_port_b_output_data_a: assert property (
		op_i == 3'h5 && addr_i == 8'h05 |=> port_b_output_data_o ==
		($past(port_b_output_data_o) | (8'h01 << $past(bit_i)))) else $error("bit set wrong");
	w1c_flag_a: assert property (
		op_i == 3'h2 && addr_i == 8'h15 && tf0_set_i == 8'h00 |=>
		timer0_flags_o == ($past(timer0_flags_o) & ~$past(wdata_i))) else $error("w1c wrong");
	skip_bit_a: assert property (
		op_i == 3'h7 && addr_i == 8'h1C |=> skip_o == $past(external_irq_flags_o[bit_i]))
		else $error("skip test sampled wrong bit");
endmodule // iosd_decoder_checker
bind iosd_decoder iosd_decoder_checker iosd_decoder_checker_inst (.core_clk_i(core_clk_i),
	.srst_i(srst_i), .op_i(op_i), .addr_i(addr_i), .bit_i(bit_i), .wdata_i(wdata_i),
	.tf0_set_i(tf0_set_i), .skip_o(skip_o), .ext_we_o(ext_we_o), .ext_addr_o(ext_addr_o),
	.port_b_output_data_o(port_b_output_data_o), .timer0_flags_o(timer0_flags_o),
	.external_irq_flags_o(external_irq_flags_o));

//--- sim/iosd_core_model.sv
// core-side model issuing i/o instructions
`timescale 1ns/1ps
module iosd_core_model (
	input logic core_clk_i,
	output logic [2:0] op_o,
	output logic [7:0] addr_o,
	output logic [2:0] bit_o,
	output logic [7:0] wdata_o,
	input logic [7:0] rdata_i,
	input logic skip_i
);
	initial begin
		op_o = 3'h0;
		addr_o = 8'h00;
		bit_o = 3'h0;
		wdata_o = 8'h00;
	end
	task automatic exec(input logic [31:0] row, output logic [7:0] rd, output logic sk);
		@(posedge core_clk_i);
		#1;
		op_o = row[30:28];
		bit_o = row[26:24];
		addr_o = row[23:16];
		wdata_o = row[15:8];
		@(posedge core_clk_i);
		#1;
		rd = rdata_i;
		sk = skip_i;
		op_o = 3'h0;
	endtask
endmodule // iosd_core_model

//--- sim/iosd_decoder_bench.sv
// self-checking bench for the i/o space decoder
`timescale 1ns/1ps
module iosd_decoder_bench;
	logic core_clk_i, srst_i, sk, skip;
	logic [2:0] op, bt;
	logic [7:0] addr, wd, rdata, pins, setp, rd, pbo, rdata_small;
	int fail_count, n_tests, cyc, i;
	// op, bit, addr, wdata, expected
	logic [31:0] rows [0:32] = '{32'h2005AA00, 32'h100500AA, 32'h40255500, 32'h30250055,
		32'h51050000, 32'h10050057, 32'h62050000, 32'h10050053, 32'h2007FF00, 32'h1007007F,
		32'h200CFF00, 32'h100C0000, 32'h20450000, 32'h10050053, 32'h100300C3, 32'h10060043,
		32'h103E0003, 32'h307000C3, 32'h10150007, 32'h20150100, 32'h10150006, 32'h20150000,
		32'h10150006, 32'h51150000, 32'h10150004, 32'h62150000, 32'h10150004, 32'h711C0001,
		32'h70150000, 32'h703E0000, 32'h40700000, 32'h40350400, 32'h10150000};
	iosd_decoder iosd_decoder_inst (.core_clk_i(core_clk_i), .srst_i(srst_i), .op_i(op),
		.addr_i(addr), .bit_i(bt), .wdata_i(wd), .port_b_input_pins_i(pins), .port_c_input_pins_i(pins[6:0]),
		.port_d_input_pins_i(pins), .tf0_set_i(setp), .tf1_set_i(setp), .tf2_set_i(setp),
		.pcf_set_i(setp), .eif_set_i(setp), .sph_i(pins), .spmc_i(pins),
		.ext_rdata_i(pins), .rdata_o(rdata), .skip_o(skip), .ext_we_o(), .ext_re_o(),
		.ext_addr_o(), .ext_wdata_o(), .port_b_direction_o(), .port_b_output_data_o(pbo),
		.port_c_direction_o(), .port_c_output_data_o(), .port_d_direction_o(),
		.port_d_output_data_o(), .timer0_flags_o(), .timer1_flags_o(), .timer2_flags_o(),
		.pin_change_flags_o(), .external_irq_flags_o(), .external_irq_mask_o());
	iosd_decoder #(.LARGE_VARIANT(0)) iosd_decoder_small_inst (.core_clk_i(core_clk_i),
		.srst_i(srst_i), .op_i(op), .addr_i(addr), .bit_i(bt), .wdata_i(wd), .port_b_input_pins_i(pins),
		.port_c_input_pins_i(pins[6:0]), .port_d_input_pins_i(pins), .tf0_set_i(setp), .tf1_set_i(setp),
		.tf2_set_i(setp), .pcf_set_i(setp), .eif_set_i(setp), .sph_i(pins), .spmc_i(pins),
		.ext_rdata_i(pins), .rdata_o(rdata_small), .skip_o(), .ext_we_o(), .ext_re_o(),
		.ext_addr_o(), .ext_wdata_o(), .port_b_direction_o(), .port_b_output_data_o(),
		.port_c_direction_o(), .port_c_output_data_o(), .port_d_direction_o(),
		.port_d_output_data_o(), .timer0_flags_o(), .timer1_flags_o(), .timer2_flags_o(),
		.pin_change_flags_o(), .external_irq_flags_o(), .external_irq_mask_o());
	iosd_core_model iosd_core_model_inst (.core_clk_i(core_clk_i), .op_o(op), .addr_o(addr),
		.bit_o(bt), .wdata_o(wd), .rdata_i(rdata), .skip_i(skip));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("tests %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			close_out;
		end
	end
	initial begin
		srst_i = 1'b1;
		pins = 8'hC3;
		setp = 8'h00;
		repeat (5) @(posedge core_clk_i);
		#1 srst_i = 1'b0;
		@(posedge core_clk_i);
		#1 setp = 8'h07;
		@(posedge core_clk_i);
		#1 setp = 8'h00;
		for (i = 0; i < 33; i++) begin
			iosd_core_model_inst.exec(rows[i], rd, sk);
			if (rows[i][30:28] == 3'h7) chk({7'h00, sk}, rows[i][7:0]);
			else if (rows[i][30:28] == 3'h1 || rows[i][30:28] == 3'h3)
				chk(rd, rows[i][7:0]);
			$display("row %0d done", i);
		end
		iosd_core_model_inst.exec(32'h10370000, rd, sk);
		chk(rd, 8'hC3);
		chk(rdata_small, 8'h83);
		$display("variant test done");
		srst_i = 1'b1;
		repeat (2) @(posedge core_clk_i);
		#1 srst_i = 1'b0;
		chk(pbo, 8'h00);
		iosd_core_model_inst.exec(32'h10150000, rd, sk);
		chk(rd, 8'h00);
		$display("reset test done");
		fork
			iosd_core_model_inst.exec(32'h20150100, rd, sk);
			begin
				@(posedge core_clk_i);
				#1 setp = 8'h01;
				@(posedge core_clk_i);
				#1 setp = 8'h00;
			end
		join
		iosd_core_model_inst.exec(32'h10150000, rd, sk);
		chk(rd, 8'h01);
		$display("set wins test done");
		close_out;
	end
endmodule // iosd_decoder_bench
